// ### hdl/vfdsc_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// - scan time bit sets digit/key slot length and dimmer step count.
// - three-bit waveform field shapes the digit pin pulse.
// - digit range 0000 enables digit pins from the first digit up to pin 15.
// - pin function enable makes selected pins act as display drivers.
// - key scan enable inserts a key scan interval in each cycle.
// - segment range 11011 enables segment pins up to pin 27, from two above the first digit.
// - first digit field picks first digit pin; 0011 gives digit 3, segment 5.
// - display on bit shows the display; cleared it blanks the digit and segment outputs.
// - run bit starts scanning.
// - flag sets at start of each key scan interval unless the first digit lies above the range's last digit.
// - key scan request reaches cpu only when enabled.
// - any write to the three config registers restarts the scan.
// - unused display RAM stays ordinary read/write RAM.
module vfdsc_top
  import vfdsc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // display pins
  output logic [DIG_PINS-1:0] digit_drive_pin_o,
  output logic [SEG_PINS-1:0] segment_drive_pin_o,
  output logic key_scan_active_o,
  // interrupt
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // registers
  vfdsc_dig_s dig_reg;
  logic [6:0] seg_ctrl_reg;
  logic [5:0] dig_begin_reg;
  logic key_scan_irq_flag_reg;
  logic key_scan_irq_enable_reg;
  logic [31:0] ram_reg [RAM_WORDS];
  logic restart_reg;
  vfdsc_state_e state_reg;
  logic [7:0] slot_cnt_reg;
  logic [4:0] dim_cnt_reg;
  logic [3:0] digit_idx_reg;
  logic key_start;

  // byte-lane merge, used for the three config registers and the display ram
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // axi write channel: take address and data in either order
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_go;
  logic wr_hit;
  logic [7:0] wr_addr;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_addr = aw_addr_reg;
  assign s_axi_bresp = 2'h0;

  // hold each half until both have arrived
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign wr_hit = wr_go;

  ////////////////////////////////////////////////////////////////////////
  // configuration registers; writes to all but the irq enable restart the scan
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dig_reg <= DIG_CTRL_RST;
      seg_ctrl_reg <= SEG_CTRL_RST;
      dig_begin_reg <= DIG_BEGIN_RST;
      key_scan_irq_enable_reg <= 1'b0;
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= 1'b0;
      if (wr_hit) begin
        unique case (wr_addr)
          DIG_CTRL_OFF: begin
            dig_reg <= vfdsc_dig_s'(8'(merge({24'h0, dig_reg}, w_data_reg, w_strb_reg)));
            restart_reg <= 1'b1;
          end
          SEG_CTRL_OFF: begin
            seg_ctrl_reg <= 7'(merge({25'h0, seg_ctrl_reg}, w_data_reg, w_strb_reg));
            restart_reg <= 1'b1;
          end
          DIG_BEGIN_OFF: begin
            dig_begin_reg <= 6'(merge({26'h0, dig_begin_reg}, w_data_reg, w_strb_reg));
            restart_reg <= 1'b1;
          end
          IRQ_EN_OFF: key_scan_irq_enable_reg <= w_strb_reg[0] ? w_data_reg[0] : key_scan_irq_enable_reg;
          default: ;
        endcase
      end
    end
  end

  // display ram: byte-lane writes, unused bits are plain storage
  always_ff @(posedge clk_i) begin
    if (wr_hit && wr_addr[7] && (wr_addr[7:2] < 6'(RAM_BASE_IDX + RAM_WORDS))) begin
      ram_reg[4'(wr_addr[5:2])] <= merge(ram_reg[4'(wr_addr[5:2])], w_data_reg, w_strb_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // key scan flag: set wins over software clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      key_scan_irq_flag_reg <= 1'b0;
    end else if (key_start) begin
      key_scan_irq_flag_reg <= 1'b1;
    end else if (wr_hit && wr_addr == IRQ_CLR_OFF && w_strb_reg[0] && w_data_reg[0]) begin
      key_scan_irq_flag_reg <= 1'b0;
    end
  end

  assign irq_o = key_scan_irq_flag_reg & key_scan_irq_enable_reg;

  ////////////////////////////////////////////////////////////////////////
  // axi read channel
  logic [31:0] rd_word;
  logic ram_rd;
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'h0;
  assign ram_rd = s_axi_araddr[7] && s_axi_araddr[6] == 1'b0;

  // read mux; unmapped addresses read zero with an okay answer
  always_comb begin
    rd_word = 32'h0;
    if (ram_rd) begin
      rd_word = ram_reg[4'(s_axi_araddr[5:2])];
    end else begin
      unique case (s_axi_araddr)
        DIG_CTRL_OFF: rd_word = {24'h0, dig_reg};
        SEG_CTRL_OFF: rd_word = {25'h0, seg_ctrl_reg};
        DIG_BEGIN_OFF: rd_word = {26'h0, dig_begin_reg};
        IRQ_STAT_OFF: rd_word = {31'h0, key_scan_irq_flag_reg};
        IRQ_EN_OFF: rd_word = {31'h0, key_scan_irq_enable_reg};
        STATUS_OFF: rd_word = {22'h0, state_reg, digit_idx_reg, 4'h0};
        default: rd_word = 32'h0;
      endcase
    end
  end

  // one read at a time, answer one cycle after the address is taken
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // scan sequencer
  logic [7:0] slot_len;
  logic [4:0] dim_last;
  logic [3:0] first_digit;
  logic [3:0] last_digit;
  logic run;
  logic key_en;

  assign slot_len = dig_reg.scan_time_select ? 8'(SLOT_LONG_CYC - 1) : 8'(SLOT_SHORT_CYC - 1);
  assign dim_last = dig_reg.scan_time_select ? 5'(DIM_STEPS_LONG - 1) : 5'(DIM_STEPS_SHORT - 1);
  assign first_digit = dig_begin_reg[DB_FIRST_LSB +: 4];
  assign last_digit = 4'hf - dig_reg.digit_pin_range;
  assign run = dig_begin_reg[DB_RUN_BIT];
  assign key_en = seg_ctrl_reg[SC_KEY_EN_BIT];
  assign key_start = (state_reg != VFDSC_KEY) && run && !restart_reg && key_en &&
                     (state_reg == VFDSC_DIGIT) && slot_cnt_reg == slot_len && digit_idx_reg == last_digit;

  // digits advance one slot at a time, key slot after the last digit
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || restart_reg || !run) begin
      state_reg <= VFDSC_IDLE;
      slot_cnt_reg <= 8'h00;
      digit_idx_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        VFDSC_IDLE: begin
          state_reg <= VFDSC_DIGIT;
          digit_idx_reg <= first_digit;
          slot_cnt_reg <= 8'h00;
        end
        VFDSC_DIGIT: begin
          slot_cnt_reg <= slot_cnt_reg + 8'h01;
          if (slot_cnt_reg == slot_len) begin
            slot_cnt_reg <= 8'h00;
            if (digit_idx_reg >= last_digit) begin
              digit_idx_reg <= first_digit;
              if (key_en) begin
                state_reg <= VFDSC_KEY;
              end
            end else begin
              digit_idx_reg <= digit_idx_reg + 4'h1;
            end
          end
        end
        VFDSC_KEY: begin
          slot_cnt_reg <= slot_cnt_reg + 8'h01;
          if (slot_cnt_reg == slot_len) begin
            slot_cnt_reg <= 8'h00;
            state_reg <= VFDSC_DIGIT;
          end
        end
      endcase
    end
  end

  // dimmer step counter wraps at the step count; nothing else reads it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || restart_reg || dim_cnt_reg == dim_last) begin
      dim_cnt_reg <= 5'h00;
    end else begin
      dim_cnt_reg <= dim_cnt_reg + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drive; waveform code trims the lit part of each slot
  logic lit;
  logic [4:0] guard;
  logic show;
  logic [4:0] seg_last;
  logic [31:0] seg_word;

  assign guard = 5'({2'h0, dig_reg.digit_waveform_select} + 5'h1);
  assign lit = (slot_cnt_reg[7:3] >= guard) && (slot_cnt_reg < slot_len - 8'(guard));
  assign show = seg_ctrl_reg[SC_PIN_EN_BIT] && dig_begin_reg[DB_DISPLAY_ON_BIT] && state_reg == VFDSC_DIGIT;
  assign seg_last = seg_ctrl_reg[SC_RANGE_LSB +: 5];
  assign seg_word = ram_reg[digit_idx_reg];

  // registered outputs; first segment pin is two above the first digit
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !show || !lit) begin
      digit_drive_pin_o <= '0;
      segment_drive_pin_o <= '0;
    end else begin
      digit_drive_pin_o <= 16'h0001 << digit_idx_reg;
      for (int s = 0; s < SEG_PINS; s++) begin
        segment_drive_pin_o[s] <= (5'(s) <= seg_last) && (5'(s) >= 5'({1'b0, first_digit} + 5'h2)) &&
                                  seg_word[s];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      key_scan_active_o <= 1'b0;
    end else begin
      key_scan_active_o <= state_reg == VFDSC_KEY;
    end
  end

endmodule

// ### include/vfdsc_pkg.sv
package vfdsc_pkg;
  // register byte offsets
  localparam logic [7:0] DIG_CTRL_OFF = 8'h00;
  localparam logic [7:0] SEG_CTRL_OFF = 8'h04;
  localparam logic [7:0] DIG_BEGIN_OFF = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h0c;
  localparam logic [7:0] IRQ_CLR_OFF = 8'h10;
  localparam logic [7:0] IRQ_EN_OFF = 8'h14;
  localparam logic [7:0] STATUS_OFF = 8'h18;
  localparam int RAM_BASE_IDX = 32;
  localparam int RAM_WORDS = 16;
  // field positions
  localparam int DC_WAVE_LSB = 0;
  localparam int DC_RANGE_LSB = 3;
  localparam int DC_SCAN_TIME_BIT = 7;
  localparam int SC_RANGE_LSB = 0;
  localparam int SC_KEY_EN_BIT = 5;
  localparam int SC_PIN_EN_BIT = 6;
  localparam int DB_FIRST_LSB = 0;
  localparam int DB_DISPLAY_ON_BIT = 4;
  localparam int DB_RUN_BIT = 5;
  // reset values
  localparam logic [7:0] DIG_CTRL_RST = 8'h00;
  localparam logic [6:0] SEG_CTRL_RST = 7'h00;
  localparam logic [5:0] DIG_BEGIN_RST = 6'h00;
  // timing, in ns and in clock cycles of the 20 ns clock
  localparam int CLK_NS = 20;
  localparam int SLOT_SHORT_NS = 1280;
  localparam int SLOT_LONG_NS = 2560;
  localparam int SLOT_SHORT_CYC = SLOT_SHORT_NS / CLK_NS;
  localparam int SLOT_LONG_CYC = SLOT_LONG_NS / CLK_NS;
  localparam int DIM_STEPS_SHORT = 16;
  localparam int DIM_STEPS_LONG = 32;
  localparam int SEG_PINS = 28;
  localparam int DIG_PINS = 16;
  // scan configuration carried as one bundle
  typedef struct packed {
    logic scan_time_select;
    logic [3:0] digit_pin_range;
    logic [2:0] digit_waveform_select;
  } vfdsc_dig_s;
  typedef enum logic [1:0] {
    VFDSC_IDLE,
    VFDSC_DIGIT,
    VFDSC_KEY
  } vfdsc_state_e;
endpackage

// ### test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import vfdsc_pkg::*;
  logic clk_i = 0, sys_rst_i = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdata, rd_v;
  logic awr, wr_r, bv, arr, rv, key, irq;
  logic [1:0] br, rr;
  logic [15:0] dig;
  logic [27:0] seg, glow;
  int miscompares = 0, checks = 0, cyc = 0, n;
  vfdsc_top uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rready),
    .digit_drive_pin_o(dig), .segment_drive_pin_o(seg), .key_scan_active_o(key), .irq_o(irq));
  vfdsc_tube tube (.clk_i(clk_i), .digit_drive_pin_i(dig), .segment_drive_pin_i(seg), .glow_o(glow));
  always #10 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////
  task final_report;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // timeout: whole run needs well under 20000 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      final_report;
    end
  end
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // handshakes are judged at the rising edge; a spare edge keeps back-to-back calls apart
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic tb;
    awa <= a; wd <= d; awv <= 1; wv <= 1; bready <= 1;
    do begin
      @(posedge clk_i);
      if (awv && awr) awv <= 0;
      if (wv && wr_r) wv <= 0;
      tb = bv;
    end while (!tb);
    bready <= 0;
    @(posedge clk_i);
  endtask
  task rd(input logic [7:0] a);
    logic tr;
    ara <= a; arv <= 1; rready <= 1;
    do begin
      @(posedge clk_i);
      if (arv && arr) arv <= 0;
      tr = rv;
      rd_v = rdata;
    end while (!tr);
    rready <= 0;
    @(posedge clk_i);
  endtask
  // waits for a lit digit pattern, n counts the cycles taken
  task wdig(input logic [15:0] v);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (dig !== v && n < 3000);
    cmp(dig, v);
  endtask
  function automatic logic [31:0] pat(input int d);
    return 32'h0a5c3000 | (d << 6);
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 0;
    @(posedge clk_i);
    rd(DIG_CTRL_OFF); cmp(rd_v, 32'(DIG_CTRL_RST));
    rd(SEG_CTRL_OFF); cmp(rd_v, 32'(SEG_CTRL_RST));
    for (int d = 0; d < RAM_WORDS; d++) wr(8'((RAM_BASE_IDX + d) * 4), pat(d));
    wr(DIG_CTRL_OFF, 32'h0);
    wr(SEG_CTRL_OFF, 27 | (1 << SC_KEY_EN_BIT) | (1 << SC_PIN_EN_BIT));
    wr(DIG_BEGIN_OFF, 3 | (1 << DB_DISPLAY_ON_BIT) | (1 << DB_RUN_BIT));
    wdig(16'h0008);
    @(negedge clk_i); cmp(32'(glow), 32'(pat(3) & 32'hfffffff));
    wdig(16'h0010);
    n = 0;
    while (!key && n < 3000) begin @(negedge clk_i); n++; end
    cmp(key, 1'b1);
    rd(IRQ_STAT_OFF); cmp(rd_v, 32'h1);
    cmp(irq, 1'b0);
    wr(IRQ_EN_OFF, 32'h1);
    cmp(irq, 1'b1);
    wr(IRQ_CLR_OFF, 32'h1);
    rd(IRQ_STAT_OFF); cmp(rd_v, 32'h0);
    cmp(irq, 1'b0);
    rd(8'(RAM_BASE_IDX * 4)); cmp(rd_v, pat(0));
    rd(8'h40); cmp(rd_v, 32'h0);
    wr(DIG_BEGIN_OFF, 5 | (1 << DB_DISPLAY_ON_BIT) | (1 << DB_RUN_BIT));
    wdig(16'h0020); cmp(n < 200, 1'b1);
    wr(DIG_CTRL_OFF, 1 << DC_SCAN_TIME_BIT);
    wdig(16'h0040);
    wdig(16'h0080); cmp(n, SLOT_LONG_CYC);
    wr(DIG_BEGIN_OFF, 5 | (1 << DB_RUN_BIT));
    repeat (4) @(negedge clk_i);
    cmp(dig, 16'h0);
    cmp(seg, 28'h0);
    final_report;
  end
endmodule

// ### test/vfdsc_asserts.sv
`timescale 1ns/100ps
module vfdsc_asserts
  import vfdsc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // bus answers
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // display and interrupt
  input wire logic [DIG_PINS-1:0] digit_drive_pin_o,
  input wire logic [SEG_PINS-1:0] segment_drive_pin_o,
  input wire logic key_scan_active_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // a key slot lasts at least eight cycles unless a write is answered within them
  sequence key_held8;
    key_scan_active_o [*8];
  endsequence
  sequence write_seen;
    ##[0:7] s_axi_bvalid;
  endsequence
  chk_digit_one_hot: assert property ($onehot0(digit_drive_pin_o))
    else $error("more than one digit lit");
  chk_key_no_digit: assert property (key_scan_active_o |-> digit_drive_pin_o == '0)
    else $error("digit lit in key slot");
  chk_key_slot_len: assert property ($rose(key_scan_active_o) |-> key_held8 or write_seen)
    else $error("key slot too short");
  // the key slot output is registered, so it shows one cycle after the flag sets
  chk_irq_cause: assert property ($rose(irq_o) |->
      ##[0:1] (key_scan_active_o || s_axi_bvalid))
    else $error("interrupt rose without cause");
  chk_reset_quiet: assert property ($fell(sys_rst_i) |->
      digit_drive_pin_o == '0 && segment_drive_pin_o == '0 && !irq_o)
    else $error("outputs active after reset");
  chk_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
    else $error("write response not okay");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule
bind vfdsc_top vfdsc_asserts u_chk (.*);

// ### test/vfdsc_tube.sv
`timescale 1ns/100ps
module vfdsc_tube
  import vfdsc_pkg::*;
(
  // inputs from the driver
  input wire logic clk_i,
  input wire logic [DIG_PINS-1:0] digit_drive_pin_i,
  input wire logic [SEG_PINS-1:0] segment_drive_pin_i,
  // what the tube shows
  output logic [SEG_PINS-1:0] glow_o
);
  // the image updates only while some grid is lit; blank grids hold the last image
  always_ff @(posedge clk_i) begin
    if (digit_drive_pin_i != '0) begin
      glow_o <= segment_drive_pin_i;
    end
  end
endmodule
